// ### rtl/trap_seq_pkg.sv
// ==========================================================
// Shared constants for the exception sequencer
package trap_seq_pkg;
   // APB register byte offsets
   localparam logic [7:0] OFS_PEND = 8'h00;   // irq_pending_reg
   localparam logic [7:0] OFS_ECLR = 8'h04;   // edge_irq_clear_reg
   localparam logic [7:0] OFS_MASK = 8'h08;   // irq_mask_reg
   localparam logic [7:0] OFS_VECT = 8'h0C;   // vector_out_reg
   localparam logic [7:0] OFS_CFG = 8'h10;    // Mode configuration
   localparam logic [7:0] OFS_BASE = 8'h14;   // dispatch_base_reg
   localparam logic [7:0] OFS_STAT = 8'h18;   // status_word view
   // Status word bit positions
   localparam int BIT_T = 1;   // Trace enable
   localparam int BIT_P = 10;  // Trace pending
   localparam int BIT_S = 9;   // Stack select
   localparam int BIT_U = 8;   // User mode
   localparam int BIT_I = 11;  // irq_enable_bit
   // Pending bit positions
   localparam int IRQ_TICK = 0;
   localparam int IRQ_DSP = 1;
   localparam int IRQ_EXT = 2;
   localparam int IRQ_CODEC = 3;
   // Dispatch vectors
   localparam logic [7:0] VEC_PRIV = 8'h04;
   localparam logic [7:0] VEC_SVC = 8'h05;
   localparam logic [7:0] VEC_DVZ = 8'h06;
   localparam logic [7:0] VEC_FLAG = 8'h07;
   localparam logic [7:0] VEC_BRK = 8'h08;
   localparam logic [7:0] VEC_TRACE = 8'h09;
   localparam logic [7:0] VEC_UND = 8'h0A;
   localparam logic [7:0] VEC_TICK = 8'h11;
   localparam logic [7:0] VEC_DSP = 8'h12;
   localparam logic [7:0] VEC_EXT = 8'h13;
   localparam logic [7:0] VEC_CODEC = 8'h14;
   // Reset values
   localparam logic [15:0] RST_STATUS = 16'h0000;
   localparam logic [3:0] RST_MASK = 4'h0;
   localparam logic [31:0] RST_BASE = 32'h0000_0000;
   // Stack item sizes in bytes
   localparam logic [31:0] PSR_BYTES = 32'h0000_0002;
   localparam logic [31:0] RA_BYTES = 32'h0000_0004;
   // Instruction trap kinds from the core
   typedef enum logic [2:0] {
      TK_PRIV, TK_SVC, TK_DVZ, TK_FLAG, TK_BRK, TK_UND
   } trap_kind_e;
endpackage

// ### rtl/trap_trace_irq_sequencer.sv
// Notes on behaviour
// RL1 - Unknown opcode: clear P, copy, clear T/U/S/P
// RL2 - Instruction traps restore start SP, status, address
// RL3 - Trap vectors 4,5,6,7,8 and unknown 10
// RL4 - Trace: clear P, copy, clear S/U/T, vector 9
// RL5 - First push status copy as 16 bits
// RL6 - Fetch table entry at vector*4 plus base
// RL7 - Push return address, then flush and refetch
// RL8 - Trace enable traps after every instruction
// RL9 - Start copies T into P; trap if P
// RL10 - Other service first, one trace per instruction
// RL11 - Unknown opcode entry never copies T to P
// RL12 - Suspended graphics loop traces on irq return
// RL13 - Wait instruction defers trace past irq service
// RL14 - Fixed priority, mask register, pollable pending
// RL15 - Four sources, vectored request to the core
// RL16 - Pin synchronised, falling edge, held three cycles
// RL17 - DSP request level: done, halt status, mask
// RL18 - Codec and tick requests on falling edges
// RL19 - All latched; edge bits cleared by clear register (the DSP bit here follows its level and is not latched)
// RL20 - Codec data access clears codec pending bit
// RL21 - Acknowledge clears irq enable; software nests
// RL22 - Software clears mask bits only irq disabled
// RL23 - Software clears pending only irq disabled
// RL24 - Power down disables the interrupt unit
// RL25 - Vectored mode takes vector from vector register
// RL26 - Config bit: zero vector or supplied vector
// RL27 - Priority codec, pin, DSP, tick; 14..11
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module trap_trace_irq_sequencer
   import trap_seq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic insn_start,        // Core begins an instruction
   input wire logic insn_boundary,     // Core ready for next one
   input wire logic trap_req,          // Instruction trap pulse
   input wire logic [2:0] trap_kind,
   input wire logic susp_string,       // Interrupted string insn
   input wire logic susp_loop,         // Interrupted graphics loop
   input wire logic wait_active,       // Wait-for-interrupt running
   input wire logic [31:0] pc_first,
   input wire logic [31:0] pc_next,
   input wire logic [31:0] sp_in,
   input wire logic status_wr,         // Core writes status word
   input wire logic [15:0] status_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic ext_irq_n,         // Asynchronous pin
   input wire logic codec_fclk,        // Codec frame clock
   input wire logic tick_clk,          // 500 Hz clock
   input wire logic dsp_list_done,
   input wire logic dsp_halt_status,
   input wire logic dsp_halt_mask,
   input wire logic codec_data_access,
   input wire logic power_down_bit,
   output logic mem_req,
   output logic mem_we,
   output logic mem_half,              // 16-bit item when high
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic pc_load,
   output logic [31:0] pc_new,
   output logic queue_flush,
   output logic [31:0] sp_out,
   output logic [15:0] status_word,
   output logic busy
);
   // ==========================================================
   // Registers and state
   typedef enum logic [2:0] {
      ST_IDLE, ST_PUSH_PSR, ST_READ_TBL, ST_PUSH_RA, ST_FLUSH
   } seq_e;
   seq_e state_r;
   logic [15:0] status_r;          // Live status word
   logic [15:0] status_start_r;    // Status at instruction start
   logic [15:0] copy_r;            // Saved copy for the stack
   logic [31:0] sp_start_r;        // SP at instruction start
   logic [31:0] sp_r;              // Working interrupt stack ptr
   logic [31:0] ra_r;              // Return address
   logic [7:0] vec_r;              // Vector in service
   logic [3:0] pend_r;             // irq_pending_reg
   logic [3:0] mask_r;             // irq_mask_reg
   logic [7:0] vout_r;             // vector_out_reg
   logic vectored_r;               // Config: vectored mode
   logic [31:0] base_r;            // dispatch_base_reg
   logic [2:0] sync1_r, sync2_r, prev_r;  // Pin/codec/tick sync
   logic apb_wr, apb_rd;
   logic [7:0] ofs;
   logic irq_hit, start_irq, start_trap, start_trace;
   logic [7:0] hit_vec, trap_vec;
   logic [3:0] live, edge_fall, clr_edge;

   assign ofs = paddr[7:0];
   assign apb_wr = psel & penable & pwrite & ~pready;
   assign apb_rd = psel & penable & ~pwrite & ~pready;

   // ==========================================================
   // Synchronisers: first stage read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 3'b111;
         sync2_r <= 3'b111;
         prev_r <= 3'b111;
      end else begin
         sync1_r <= {tick_clk, codec_fclk, ext_irq_n};  // [RL16]
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // Falling edges; pin needs three low cycles to be safe
   always_comb begin
      edge_fall = 4'h0;
      edge_fall[IRQ_EXT] = prev_r[0] & ~sync2_r[0];    // [RL16]
      edge_fall[IRQ_CODEC] = prev_r[1] & ~sync2_r[1];  // [RL18]
      edge_fall[IRQ_TICK] = prev_r[2] & ~sync2_r[2];   // [RL18]
   end

   // ==========================================================
   // Pending latch; a new edge beats a clear in the same cycle
   always_comb begin
      clr_edge = 4'h0;
      if (apb_wr && ofs == OFS_ECLR) begin
         clr_edge = pwdata[3:0];                       // [RL19]
      end
      clr_edge[IRQ_CODEC] = clr_edge[IRQ_CODEC] | codec_data_access; // [RL20]
      clr_edge[IRQ_DSP] = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= 4'h0;
      end else if (power_down_bit) begin
         pend_r <= pend_r;                             // [RL24]
      end else begin
         pend_r <= (pend_r & ~clr_edge) | edge_fall;   // [RL19]
         // Level request follows the DSP state directly
         pend_r[IRQ_DSP] <= dsp_list_done & dsp_halt_status
            & dsp_halt_mask;                           // [RL17]
      end
   end

   // Fixed priority over unmasked pending requests
   always_comb begin
      live = pend_r & mask_r;                          // [RL14]
      hit_vec = 8'h00;
      if (live[IRQ_CODEC]) begin
         hit_vec = VEC_CODEC;                          // [RL27]
      end else if (live[IRQ_EXT]) begin
         hit_vec = VEC_EXT;
      end else if (live[IRQ_DSP]) begin
         hit_vec = VEC_DSP;
      end else begin
         hit_vec = VEC_TICK;
      end
   end
   assign irq_hit = (|live) & status_r[BIT_I] & ~power_down_bit; // [RL24]

   // ==========================================================
   // Entry arbitration; traps first, then irq, then trace
   assign start_trap = (state_r == ST_IDLE) & trap_req;
   assign start_irq = (state_r == ST_IDLE) & ~trap_req & insn_boundary
      & irq_hit;                                       // [RL10]
   assign start_trace = (state_r == ST_IDLE) & ~trap_req & insn_boundary
      & ~irq_hit & status_r[BIT_P] & ~wait_active;     // [RL13]

   always_comb begin
      case (trap_kind)
         TK_PRIV: trap_vec = VEC_PRIV;                 // [RL3]
         TK_SVC: trap_vec = VEC_SVC;
         TK_DVZ: trap_vec = VEC_DVZ;
         TK_FLAG: trap_vec = VEC_FLAG;
         TK_BRK: trap_vec = VEC_BRK;
         default: trap_vec = VEC_UND;
      endcase
   end

   // ==========================================================
   // Status word; entries copy then clear control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= RST_STATUS;
         copy_r <= RST_STATUS;
         status_start_r <= RST_STATUS;
      end else if (start_trap) begin
         // Restore start value; unknown opcode drops P first
         copy_r <= status_start_r;                     // [RL2]
         if (trap_kind == TK_UND) begin
            copy_r[BIT_P] <= 1'b0;                     // [RL1]
         end
         status_r <= status_start_r;
         status_r[BIT_T] <= 1'b0;
         status_r[BIT_U] <= 1'b0;
         status_r[BIT_S] <= 1'b0;
         status_r[BIT_P] <= 1'b0;                      // [RL1]
      end else if (start_irq) begin
         // Loop insn keeps P so trace fires after return
         copy_r <= status_r;                           // [RL12]
         copy_r[BIT_P] <= status_r[BIT_P] & ~susp_string;
         status_r[BIT_T] <= 1'b0;
         status_r[BIT_U] <= 1'b0;
         status_r[BIT_S] <= 1'b0;
         status_r[BIT_P] <= 1'b0;
         status_r[BIT_I] <= 1'b0;                      // [RL21]
      end else if (start_trace) begin
         copy_r <= status_r;
         copy_r[BIT_P] <= 1'b0;                        // [RL4]
         status_r[BIT_T] <= 1'b0;
         status_r[BIT_U] <= 1'b0;
         status_r[BIT_S] <= 1'b0;
         status_r[BIT_P] <= 1'b0;
      end else if (status_wr) begin
         status_r <= status_wdata;                     // Return ops
      end else if (insn_start) begin
         // Trap entries never raise insn_start
         status_r[BIT_P] <= status_r[BIT_T];           // [RL9] [RL11]
         status_start_r <= status_r;
         status_start_r[BIT_P] <= status_r[BIT_T];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_start_r <= 32'h0000_0000;
      end else if (insn_start) begin
         sp_start_r <= sp_in;                          // [RL2]
      end
   end

   // ==========================================================
   // Service sequence: push status, table read, push address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         vec_r <= 8'h00;
         ra_r <= 32'h0000_0000;
         sp_r <= 32'h0000_0000;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_half <= 1'b0;
         mem_addr <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
         pc_load <= 1'b0;
         pc_new <= 32'h0000_0000;
         queue_flush <= 1'b0;
         vout_r <= 8'h00;
      end else begin
         pc_load <= 1'b0;
         queue_flush <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start_trap) begin
                  vec_r <= trap_vec;                   // [RL3]
                  ra_r <= pc_first;                    // [RL2]
                  sp_r <= sp_start_r;
                  state_r <= ST_PUSH_PSR;
               end else if (start_irq) begin
                  vout_r <= hit_vec;                   // [RL25]
                  vec_r <= vectored_r ? hit_vec : 8'h00; // [RL26]
                  ra_r <= (susp_string | susp_loop) ? pc_first : pc_next;
                  sp_r <= sp_in;
                  state_r <= ST_PUSH_PSR;              // [RL15]
               end else if (start_trace) begin
                  vec_r <= VEC_TRACE;                  // [RL4] [RL8]
                  ra_r <= pc_next;
                  sp_r <= sp_in;
                  state_r <= ST_PUSH_PSR;
               end
            end
            ST_PUSH_PSR: begin
               mem_req <= ~mem_ack;
               mem_we <= 1'b1;
               mem_half <= 1'b1;                       // [RL5]
               mem_addr <= sp_r - PSR_BYTES;
               mem_wdata <= {16'h0000, copy_r};
               if (mem_ack && mem_req) begin
                  sp_r <= sp_r - PSR_BYTES;
                  mem_req <= 1'b0;
                  state_r <= ST_READ_TBL;
               end
            end
            ST_READ_TBL: begin
               mem_req <= ~mem_ack;
               mem_we <= 1'b0;
               mem_half <= 1'b0;
               mem_addr <= {22'h00_0000, vec_r, 2'b00} + base_r; // [RL6]
               if (mem_ack && mem_req) begin
                  pc_new <= mem_rdata;                 // [RL6]
                  pc_load <= 1'b1;
                  mem_req <= 1'b0;
                  state_r <= ST_PUSH_RA;
               end
            end
            ST_PUSH_RA: begin
               mem_req <= ~mem_ack;
               mem_we <= 1'b1;
               mem_half <= 1'b0;
               mem_addr <= sp_r - RA_BYTES;            // [RL7]
               mem_wdata <= ra_r;
               if (mem_ack && mem_req) begin
                  sp_r <= sp_r - RA_BYTES;
                  mem_req <= 1'b0;
                  state_r <= ST_FLUSH;
               end
            end
            ST_FLUSH: begin
               queue_flush <= 1'b1;                    // [RL7]
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // APB slave: one wait state, error on unmapped or power down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         mask_r <= RST_MASK;
         vectored_r <= 1'b0;
         base_r <= RST_BASE;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if ((apb_wr || apb_rd) && power_down_bit) begin
            pslverr <= 1'b1;                           // [RL24]
         end else if (apb_wr) begin
            case (ofs)
               OFS_ECLR: ;
               OFS_MASK: mask_r <= pwdata[3:0];        // [RL14]
               OFS_CFG: vectored_r <= pwdata[0];       // [RL26]
               OFS_BASE: base_r <= pwdata;
               default: pslverr <= 1'b1;
            endcase
         end else if (apb_rd) begin
            case (ofs)
               OFS_PEND: prdata <= {28'h000_0000, pend_r}; // [RL14]
               OFS_ECLR: prdata <= 32'h0000_0000;
               OFS_MASK: prdata <= {28'h000_0000, mask_r};
               OFS_VECT: prdata <= {24'h00_0000, vout_r};
               OFS_CFG: prdata <= {31'h0000_0000, vectored_r};
               OFS_BASE: prdata <= base_r;
               OFS_STAT: prdata <= {16'h0000, status_r};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Registered mirrors of internal state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_out <= 32'h0000_0000;
         status_word <= RST_STATUS;
         busy <= 1'b0;
      end else begin
         sp_out <= sp_r;
         status_word <= status_r;
         busy <= (state_r != ST_IDLE) | start_trap | start_irq | start_trace;
      end
   end

   // ==========================================================
   // Checks
   sequence s_psr_push;
      state_r == ST_PUSH_PSR && mem_req && mem_ack;
   endsequence
   property p_trace_vec;
      @(posedge pclk) disable iff (!presetn)
      start_trace |=> vec_r == VEC_TRACE && !copy_r[BIT_P] && ra_r == $past(pc_next);
   endproperty
   a_trace_vec: assert property (p_trace_vec) else $error("trace entry wrong"); // [RL4]
   property p_und_clear;
      @(posedge pclk) disable iff (!presetn)
      start_trap && trap_kind == TK_UND |=> vec_r == VEC_UND && !copy_r[BIT_P] && !status_r[BIT_T];
   endproperty
   a_und_clear: assert property (p_und_clear) else $error("unknown trap wrong"); // [RL1]
   property p_half_push;
      @(posedge pclk) disable iff (!presetn)
      s_psr_push |-> mem_half && mem_we ##1 state_r == ST_READ_TBL;
   endproperty
   a_half_push: assert property (p_half_push) else $error("status push wrong"); // [RL5]
   property p_tbl_addr;
      @(posedge pclk) disable iff (!presetn)
      state_r == ST_READ_TBL && mem_req |-> mem_addr == ({22'h00_0000, vec_r, 2'b00} + base_r);
   endproperty
   a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong"); // [RL6]
   property p_flush;
      @(posedge pclk) disable iff (!presetn)
      state_r == ST_PUSH_RA && mem_req && mem_ack |=> ##1 queue_flush;
   endproperty
   a_flush: assert property (p_flush) else $error("no flush after push"); // [RL7]
   property p_ack_clears_i;
      @(posedge pclk) disable iff (!presetn)
      start_irq |=> !status_r[BIT_I] ##1 busy;
   endproperty
   a_ack_clears_i: assert property (p_ack_clears_i) else $error("irq enable kept"); // [RL21]
   property p_codec_first;
      @(posedge pclk) disable iff (!presetn)
      start_irq && live[IRQ_CODEC] && vectored_r |=> vec_r == VEC_CODEC;
   endproperty
   a_codec_first: assert property (p_codec_first) else $error("priority wrong"); // [RL27]
   property p_pd_frozen;
      @(posedge pclk) disable iff (!presetn)
      power_down_bit && $past(power_down_bit) |-> $stable(pend_r) && !start_irq;
   endproperty
   a_pd_frozen: assert property (p_pd_frozen) else $error("unit active in power down"); // [RL24]
   property p_no_trace_wait;
      @(posedge pclk) disable iff (!presetn)
      wait_active && !trap_req && !irq_hit && state_r == ST_IDLE |=> !busy;
   endproperty
   a_no_trace_wait: assert property (p_no_trace_wait) else $error("trace during wait"); // [RL13]
endmodule // trap_trace_irq_sequencer
`default_nettype wire

// ### tb/core_stack_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Stack and dispatch table memory of the core
module core_stack_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic [3:0] slow,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [3:0] wait_r; // Cycles left before answering
   // One-cycle ack after a chosen delay; data scrambled when idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0000_0000;
         wait_r <= 4'h0;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata; // Alternates the old entry and its inverse
         if (mem_req && !mem_ack) begin
            if (wait_r == 4'h0) begin
               mem_ack <= 1'b1;
               mem_rdata <= mem_addr ^ 32'hA5A5_0000;
               wait_r <= slow;
            end else begin
               wait_r <= wait_r - 4'h1;
            end
         end
      end
   end
endmodule // core_stack_model
`default_nettype wire

// ### tb/tb_trap_trace_irq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench
module tb_trap_trace_irq_sequencer import trap_seq_pkg::*; ;
   typedef struct packed {
      logic we;
      logic half;
      logic [31:0] a;
      logic [31:0] d;
   } acc_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd, base, seed, pc_new, sp_out;
   logic insn_start, insn_boundary, trap_req, susp_string, susp_loop, busy;
   logic wait_active, status_wr, mem_ack, ext_irq_n, codec_fclk, tick_clk;
   logic dsp_list_done, dsp_halt_status, dsp_halt_mask, codec_data_access;
   logic power_down_bit, mem_req, mem_we, mem_half, pc_load, queue_flush;
   logic [2:0] trap_kind;
   logic [31:0] pc_first, pc_next, sp_in, mem_rdata, mem_addr, mem_wdata;
   logic [15:0] status_wdata, status_word;
   logic [3:0] slow; // Memory answer delay
   logic [7:0] vt [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A};
   int n_fail, n_tests, cyc, n_flush, n_seen;
   acc_s e;
   acc_s exp_q[$]; // Expected memory steps
   logic [31:0] pc_q[$]; // Expected handler addresses
   trap_trace_irq_sequencer trap_trace_irq_sequencer_inst (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .insn_start, .insn_boundary, .trap_req, .trap_kind, .susp_string,
      .susp_loop, .wait_active, .pc_first, .pc_next, .sp_in, .status_wr,
      .status_wdata, .mem_ack, .mem_rdata, .ext_irq_n, .codec_fclk,
      .tick_clk, .dsp_list_done, .dsp_halt_status, .dsp_halt_mask,
      .codec_data_access, .power_down_bit, .mem_req, .mem_we, .mem_half,
      .mem_addr, .mem_wdata, .pc_load, .pc_new, .queue_flush, .sp_out,
      .status_word, .busy);
   core_stack_model core_stack_model_inst (.pclk, .presetn, .mem_req,
      .mem_addr, .slow, .mem_ack, .mem_rdata);
   // ==========================================
   // Helpers
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, x, g);
      end
   endtask
   // APB master; request held until pready is sampled
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h00_0000, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk("prdata", x, rd);
   endtask
   // One-cycle core pulse: 0 status, 1 start, 2 boundary, 3 trap, 4 codec
   task automatic core(input int op);
      @(posedge pclk);
      status_wr <= (op == 0);
      insn_start <= (op == 1);
      insn_boundary <= (op == 2);
      trap_req <= (op == 3);
      codec_data_access <= (op == 4);
      @(posedge pclk);
      {status_wr, insn_start, insn_boundary, trap_req} <= 4'h0;
      codec_data_access <= 1'b0;
   endtask
   // Notes the three steps of one service
   task automatic serve(input logic [7:0] v, input logic [15:0] cp,
                        input logic [31:0] ra);
      logic [31:0] ta;
      ta = ({24'h00_0000, v} << 2) + base;
      exp_q.push_back('{1'b1, 1'b1, sp_in - 32'h0000_0002, 32'(cp)});
      exp_q.push_back('{1'b0, 1'b0, ta, 32'h0000_0000});
      exp_q.push_back('{1'b1, 1'b0, sp_in - 32'h0000_0006, ra});
      pc_q.push_back(ta ^ 32'hA5A5_0000);
      n_flush++;
   endtask
   task automatic idle;
      @(posedge pclk);
      while (busy !== 1'b0) @(posedge pclk);
   endtask
   task automatic end_sim;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================
   // Monitor: memory steps, handler load, flush, timeout
   always @(posedge pclk) begin
      if (mem_req === 1'b1 && mem_ack === 1'b1) begin
         e = exp_q.pop_front();
         chk("mem_addr", e.a, mem_addr);
         chk("mem_we", 32'(e.we), 32'(mem_we));
         chk("mem_half", 32'(e.half), 32'(mem_half));
         if (e.half) chk("wdata16", e.d, 32'(mem_wdata[15:0]));
         else if (e.we) chk("wdata32", e.d, mem_wdata);
      end
      if (pc_load === 1'b1) chk("pc_new", pc_q.pop_front(), pc_new);
      if (queue_flush === 1'b1) n_seen++;
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         end_sim();
      end
   end
   // ==========================================
   // Scenarios
   initial begin
      {psel, penable, pwrite, paddr, pwdata, trap_kind} = '0;
      {insn_start, insn_boundary, trap_req, susp_string, susp_loop} = '0;
      {wait_active, status_wr, status_wdata, dsp_list_done} = '0;
      {dsp_halt_status, dsp_halt_mask, codec_data_access} = '0;
      {ext_irq_n, codec_fclk, tick_clk, power_down_bit} = 4'hE;
      slow = 4'h0;
      seed = lfsr(32'h0000_0061);
      sp_in = seed & 32'hFFFF_FFFC;
      seed = lfsr(seed);
      base = seed & 32'h0000_FFFC;
      pc_first = lfsr(seed);
      pc_next = pc_first + 32'h0000_0003;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rchk(OFS_MASK, 32'h0000_0000);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, 32'(err));
      apb(1'b1, OFS_BASE, base);
      // Every instruction trap, memory answers ever slower
      for (int k = 0; k < 6; k++) begin
         slow <= 4'(k);
         trap_kind <= 3'(k);
         status_wdata <= 16'h0102;
         core(0);
         core(1);
         serve(vt[k], (k == 5) ? 16'h0102 : 16'h0502, pc_first);
         core(3);
         idle();
         chk("status_word", 32'h0000_0000, 32'(status_word));
      end
      // Trace held off by wait
      status_wdata <= 16'h0002;
      core(0);
      core(1);
      wait_active <= 1'b1;
      core(2);
      repeat (3) @(posedge pclk);
      chk("busy", 32'h0000_0000, 32'(busy));
      wait_active <= 1'b0;
      serve(8'h09, 16'h0002, pc_next);
      core(2);
      idle();
      chk("status_word", 32'h0000_0000, 32'(status_word));
      // Vectored interrupt, codec beats tick
      apb(1'b1, OFS_MASK, 32'h0000_000F);
      apb(1'b1, OFS_CFG, 32'h0000_0001);
      codec_fclk <= 1'b0;
      tick_clk <= 1'b0;
      repeat (6) @(posedge pclk);
      rchk(OFS_PEND, 32'h0000_0009);
      status_wdata <= 16'h0800;
      core(0);
      serve(8'h14, 16'h0800, pc_next);
      core(2);
      idle();
      chk("status_word", 32'h0000_0000, 32'(status_word));
      rchk(OFS_VECT, 32'h0000_0014);
      core(4);
      rchk(OFS_PEND, 32'h0000_0001);
      // Non-vectored: zero vector, register still shows winner
      apb(1'b1, OFS_CFG, 32'h0000_0000);
      {susp_loop, status_wdata} <= 17'h1_0802;
      core(0);
      core(1);
      serve(8'h00, 16'h0C02, pc_first);
      core(2);
      idle();
      rchk(OFS_VECT, 32'h0000_0011);
      apb(1'b1, OFS_ECLR, 32'h0000_0001); // Cleared with irqs off
      rchk(OFS_PEND, 32'h0000_0000);
      // Pin held low three cycles, DSP level request
      ext_irq_n <= 1'b0;
      {dsp_list_done, dsp_halt_status, dsp_halt_mask} <= 3'h7;
      repeat (3) @(posedge pclk);
      ext_irq_n <= 1'b1;
      repeat (4) @(posedge pclk);
      rchk(OFS_PEND, 32'h0000_0006);
      dsp_halt_mask <= 1'b0;
      repeat (2) @(posedge pclk);
      rchk(OFS_PEND, 32'h0000_0004);
      power_down_bit <= 1'b1;
      apb(1'b0, OFS_PEND, 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, 32'(err));
      power_down_bit <= 1'b0;
      apb(1'b1, OFS_MASK, 32'h0000_0000); // Irqs are off here
      chk("flushes", n_flush, n_seen);
      chk("open_steps", 32'h0000_0000, exp_q.size());
      end_sim();
   end
endmodule // tb_trap_trace_irq_sequencer
`default_nettype wire
